/* srlc_boost.sv */
// boost phase timer for synthesizer start-up
`timescale 1ns/1ps
module srlc_boost #(
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic synth_en,
    input wire logic boost_en,
    input wire logic [LEN_W-1:0] boost_len,
    // status
    output logic fast_active,
    output logic boost_end
);
    initial begin
        if (LEN_W < 1) begin
            $error("srlc_boost: LEN_W must be positive");
        end
    end
    logic [LEN_W-1:0] cnt_q;
    logic en_q;
    // counts reference cycles from synthesizer enable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= '0;
            en_q <= 1'b0;
            fast_active <= 1'b0;
            boost_end <= 1'b0;
        end else begin
            en_q <= synth_en;
            boost_end <= 1'b0;
            if (!synth_en) begin
                fast_active <= 1'b0;
                cnt_q <= '0;
            end else if (!en_q) begin
                fast_active <= boost_en && (boost_len != '0);
                cnt_q <= '0;
            end else if (fast_active) begin
                if (cnt_q + 1'b1 >= boost_len) begin
                    fast_active <= 1'b0;
                    boost_end <= 1'b1;
                end
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule : srlc_boost

/* srlc_pkg.sv */
// package for the synthesizer ranging and loop control block
package srlc_pkg;
    // register offsets (word index times four)
    localparam logic [7:0] OFF_CARRIER_A = 8'h00;
    localparam logic [7:0] OFF_CARRIER_B = 8'h04;
    localparam logic [7:0] OFF_DIVIDER = 8'h08;
    localparam logic [7:0] OFF_RANGING_A = 8'h0c;
    localparam logic [7:0] OFF_RANGING_B = 8'h10;
    localparam logic [7:0] OFF_LOOP = 8'h14;
    localparam logic [7:0] OFF_LOOP_FAST = 8'h18;
    localparam logic [7:0] OFF_CP = 8'h1c;
    localparam logic [7:0] OFF_CP_FAST = 8'h20;
    localparam logic [7:0] OFF_BOOST = 8'h24;
    localparam logic [7:0] OFF_SYNTH = 8'h28;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h2c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
    // field positions
    localparam int RNG_RANGE_LSB = 0;
    localparam int RNG_GO_BIT = 4;
    localparam int RNG_FAULT_BIT = 5;
    localparam int RNG_TRACK_BIT = 6;
    localparam int DIV_REF_LSB = 0;
    localparam int DIV_OUT_LSB = 8;
    localparam int BOOST_EN_BIT = 16;
    localparam int IRQ_DONE_A = 0;
    localparam int IRQ_DONE_B = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_BOOST_END = 3;
    // reset values
    localparam logic [31:0] RST_CARRIER = 32'h0000_0000;
    localparam logic [7:0] RST_REF_DIV = 8'h01;
    localparam logic [3:0] RST_OUT_DIV = 4'h1;
    localparam logic [3:0] RST_RANGE = 4'h8;
    localparam logic [1:0] RST_FLT = 2'h1;
    localparam logic [7:0] RST_CP = 8'h08;
    localparam logic [15:0] RST_BOOST_LEN = 16'h0100;
    // ranging timing: settle time per step
    localparam int SETTLE_US = 4;
    localparam int CLK_MHZ = 25;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    // loop filter selections
    localparam logic [1:0] FLT_EXTERNAL = 2'h0;
    // software port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } srlc_req_t;
    // settings presented to the analog loop
    typedef struct packed {
        logic [1:0] loop_filter_sel;
        logic [7:0] charge_pump;
        logic external_filter_pin;
    } srlc_loop_t;
endpackage : srlc_pkg

/* srlc_ranger.sv */
// oscillator range search engine with optional drift tracking
`timescale 1ns/1ps
module srlc_ranger #(
    parameter int RANGE_W = 4,
    parameter int SETTLE = 100
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command
    input wire logic start,
    input wire logic track_en,
    input wire logic [RANGE_W-1:0] init_range,
    // comparator from the analog loop: tune voltage high / low
    input wire logic vco_high,
    input wire logic vco_low,
    // results
    output logic busy,
    output logic done,
    output logic fault,
    output logic [RANGE_W-1:0] range
);
    initial begin
        if (RANGE_W < 2 || SETTLE < 1) begin
            $error("srlc_ranger: bad parameters");
        end
    end
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_SETTLE = 3'b010,
        S_JUDGE = 3'b100
    } srlc_rng_st_t;
    srlc_rng_st_t st_q;
    logic [RANGE_W-1:0] step_q;
    logic [15:0] tmr_q;
    logic [15:0] trk_q;
    localparam logic [15:0] SETTLE_M1 = 16'(SETTLE - 1);
    // binary search from the loaded init_range down to one step, then track
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            step_q <= '0;
            tmr_q <= '0;
            trk_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
            range <= '0;
        end else begin
            done <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    trk_q <= trk_q + 16'h0001;
                    if (start) begin
                        busy <= 1'b1;
                        fault <= 1'b0;
                        range <= init_range;
                        step_q <= RANGE_W'(1 << (RANGE_W - 2));
                        tmr_q <= '0;
                        st_q <= S_SETTLE;
                    end else if (track_en && trk_q == 16'hffff) begin
                        // slow drift: nudge one step toward centre
                        if (vco_high && range != '1) begin
                            range <= range + 1'b1;
                        end else if (vco_low && range != '0) begin
                            range <= range - 1'b1;
                        end
                    end
                end
                S_SETTLE: begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (tmr_q == SETTLE_M1) begin
                        st_q <= S_JUDGE;
                    end
                end
                S_JUDGE: begin
                    tmr_q <= '0;
                    if (step_q == '0) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        fault <= vco_high || vco_low;
                        st_q <= S_IDLE;
                    end else begin
                        if (vco_high) begin
                            range <= range + step_q;
                        end else if (vco_low) begin
                            range <= range - step_q;
                        end
                        step_q <= step_q >> 1;
                        st_q <= S_SETTLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule : srlc_ranger

/* srlc_top.sv */
// synthesizer carrier, divider, ranging and loop setting control
// How it works
// - carrier words are written as whole hertz counts, one per step
// - two carrier words, set A and set B, are kept apart
// - output divider field drives the synthesizer output division port
// - reference divider field drives the reference division port
// - writing one to a ranging go bit starts the range search; a go write while a search is running is ignored
// - go bit reads one while searching and zero when finished
// - search from control A uses carrier A, from B uses carrier B
// - fault flag tells whether the last search ended correctly
// - optional tracking mode corrects the range for slow drift
// - two-bit filter select in both loop registers picks the filter
// - eight-bit charge pump field in both pump registers sets current
// - boost settings apply at synthesizer start for a set time
// - filter select zero routes tune voltage to the external pin
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module srlc_top #(
    parameter int RANGE_W = 4,
    parameter int BOOST_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // interrupt
    output logic irq,
    // analog loop: comparator pins
    input wire logic vco_high_pin,
    input wire logic vco_low_pin,
    // analog loop: settings
    output logic [31:0] carrier_word,
    output logic [7:0] reference_divider_ratio,
    output logic [3:0] output_band_divider,
    output logic [RANGE_W-1:0] vco_range,
    output srlc_pkg::srlc_loop_t loop_out,
    output logic synth_en
);
    initial begin
        if (RANGE_W < 2 || RANGE_W > 4 || BOOST_W < 1 || BOOST_W > 16) begin
            $error("srlc_top: unsupported parameters");
        end
    end
    srlc_pkg::srlc_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    // registers
    logic [31:0] carrier_word_a_q;
    logic [31:0] carrier_word_b_q;
    logic [7:0] ref_div_q;
    logic [3:0] out_div_q;
    logic [RANGE_W-1:0] range_a_q;
    logic [RANGE_W-1:0] range_b_q;
    logic track_a_q;
    logic track_b_q;
    logic fault_a_q;
    logic fault_b_q;
    logic [1:0] flt_q;
    logic [1:0] flt_fast_q;
    logic [7:0] cp_q;
    logic [7:0] cp_fast_q;
    logic boost_en_q;
    logic [BOOST_W-1:0] boost_len_q;
    logic synth_en_q;
    logic use_b_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [3:0] irq_set;
    logic sel_b_q;

    // synchroniser for the analog comparator pins
    logic [1:0] hi_sync_q;
    logic [1:0] lo_sync_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hi_sync_q <= 2'h0;
            lo_sync_q <= 2'h0;
        end else begin
            hi_sync_q <= {hi_sync_q[0], vco_high_pin};
            lo_sync_q <= {lo_sync_q[0], vco_low_pin};
        end
    end

    function automatic logic hit(input srlc_pkg::srlc_req_t r,
                                 input logic [7:0] off);
        hit = r.wr && (r.addr == off);
    endfunction : hit

    // range search engine
    logic go_a;
    logic go_b;
    logic ranging_go;
    logic rng_busy;
    logic rng_done;
    logic rng_fault;
    logic [RANGE_W-1:0] rng_range;
    logic [RANGE_W-1:0] init_range;
    assign go_a = hit(req, srlc_pkg::OFF_RANGING_A)
        && wdata[srlc_pkg::RNG_GO_BIT];
    assign go_b = hit(req, srlc_pkg::OFF_RANGING_B)
        && wdata[srlc_pkg::RNG_GO_BIT];
    assign ranging_go = (go_a || go_b) && !rng_busy;
    assign init_range = go_b ? wdata[RANGE_W-1:0] : wdata[RANGE_W-1:0];

    srlc_ranger #(
        .RANGE_W(RANGE_W),
        .SETTLE(srlc_pkg::SETTLE_CYC)
    ) u_ranger (
        .clock(clock),
        .rst_n(rst_n),
        .start(ranging_go),
        .track_en(sel_b_q ? track_b_q : track_a_q),
        .init_range(init_range),
        .vco_high(hi_sync_q[1]),
        .vco_low(lo_sync_q[1]),
        .busy(rng_busy),
        .done(rng_done),
        .fault(rng_fault),
        .range(rng_range)
    );

    // which set the engine works on
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_b_q <= 1'b0;
        end else if (ranging_go) begin
            sel_b_q <= go_b;
        end else if (!rng_busy) begin
            sel_b_q <= use_b_q;
        end
    end

    // boost timer
    logic fast_active;
    logic boost_end;
    srlc_boost #(
        .LEN_W(BOOST_W)
    ) u_boost (
        .clock(clock),
        .rst_n(rst_n),
        .synth_en(synth_en_q),
        .boost_en(boost_en_q),
        .boost_len(boost_len_q),
        .fast_active(fast_active),
        .boost_end(boost_end)
    );

    // carrier words and dividers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            carrier_word_a_q <= srlc_pkg::RST_CARRIER;
            carrier_word_b_q <= srlc_pkg::RST_CARRIER;
            ref_div_q <= srlc_pkg::RST_REF_DIV;
            out_div_q <= srlc_pkg::RST_OUT_DIV;
        end else begin
            if (hit(req, srlc_pkg::OFF_CARRIER_A)) begin
                carrier_word_a_q <= wdata;
            end
            if (hit(req, srlc_pkg::OFF_CARRIER_B)) begin
                carrier_word_b_q <= wdata;
            end
            if (hit(req, srlc_pkg::OFF_DIVIDER)) begin
                ref_div_q <= wdata[srlc_pkg::DIV_REF_LSB +: 8];
                out_div_q <= wdata[srlc_pkg::DIV_OUT_LSB +: 4];
            end
        end
    end

    // ranging results per set, tracking kept to the live set
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            range_a_q <= RANGE_W'(srlc_pkg::RST_RANGE);
            range_b_q <= RANGE_W'(srlc_pkg::RST_RANGE);
            track_a_q <= 1'b0;
            track_b_q <= 1'b0;
            fault_a_q <= 1'b0;
            fault_b_q <= 1'b0;
        end else begin
            if (hit(req, srlc_pkg::OFF_RANGING_A)) begin
                track_a_q <= wdata[srlc_pkg::RNG_TRACK_BIT];
            end
            if (hit(req, srlc_pkg::OFF_RANGING_B)) begin
                track_b_q <= wdata[srlc_pkg::RNG_TRACK_BIT];
            end
            if (ranging_go) begin
                if (go_b) begin
                    fault_b_q <= 1'b0;
                end else begin
                    fault_a_q <= 1'b0;
                end
            end else if (rng_busy || rng_done ||
                         (sel_b_q ? track_b_q : track_a_q)) begin
                if (sel_b_q) begin
                    range_b_q <= rng_range;
                end else begin
                    range_a_q <= rng_range;
                end
            end
            if (rng_done) begin
                if (sel_b_q) begin
                    fault_b_q <= rng_fault;
                end else begin
                    fault_a_q <= rng_fault;
                end
            end
        end
    end

    // loop filter, charge pump, boost and synthesizer control
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flt_q <= srlc_pkg::RST_FLT;
            flt_fast_q <= srlc_pkg::RST_FLT;
            cp_q <= srlc_pkg::RST_CP;
            cp_fast_q <= srlc_pkg::RST_CP;
            boost_en_q <= 1'b0;
            boost_len_q <= BOOST_W'(srlc_pkg::RST_BOOST_LEN);
            synth_en_q <= 1'b0;
            use_b_q <= 1'b0;
        end else begin
            if (hit(req, srlc_pkg::OFF_LOOP)) begin
                flt_q <= wdata[1:0];
            end
            if (hit(req, srlc_pkg::OFF_LOOP_FAST)) begin
                flt_fast_q <= wdata[1:0];
            end
            if (hit(req, srlc_pkg::OFF_CP)) begin
                cp_q <= wdata[7:0];
            end
            if (hit(req, srlc_pkg::OFF_CP_FAST)) begin
                cp_fast_q <= wdata[7:0];
            end
            if (hit(req, srlc_pkg::OFF_BOOST)) begin
                boost_len_q <= wdata[BOOST_W-1:0];
                boost_en_q <= wdata[srlc_pkg::BOOST_EN_BIT];
            end
            if (hit(req, srlc_pkg::OFF_SYNTH)) begin
                synth_en_q <= wdata[0];
                use_b_q <= wdata[1];
            end
        end
    end

    // interrupt status: set wins over write-one-to-clear
    assign irq_set = {boost_end, rng_done && rng_fault,
                      rng_done && sel_b_q, rng_done && !sel_b_q};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else begin
            if (hit(req, srlc_pkg::OFF_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~wdata[3:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (hit(req, srlc_pkg::OFF_IRQ_MASK)) begin
                irq_mask_q <= wdata[3:0];
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // outputs to the analog loop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            carrier_word <= srlc_pkg::RST_CARRIER;
            reference_divider_ratio <= srlc_pkg::RST_REF_DIV;
            output_band_divider <= srlc_pkg::RST_OUT_DIV;
            vco_range <= RANGE_W'(srlc_pkg::RST_RANGE);
            loop_out <= '0;
            synth_en <= 1'b0;
        end else begin
            carrier_word <= sel_b_q ? carrier_word_b_q
                                    : carrier_word_a_q;
            reference_divider_ratio <= ref_div_q;
            output_band_divider <= out_div_q;
            vco_range <= rng_busy ? rng_range
                       : (sel_b_q ? range_b_q : range_a_q);
            loop_out.loop_filter_sel <= fast_active ? flt_fast_q : flt_q;
            loop_out.charge_pump <= fast_active ? cp_fast_q : cp_q;
            loop_out.external_filter_pin <= (fast_active ? flt_fast_q : flt_q)
                == srlc_pkg::FLT_EXTERNAL;
            synth_en <= synth_en_q;
        end
    end

    // read data, one cycle after the read strobe
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (addr == srlc_pkg::OFF_CARRIER_A) begin
            rd_d = carrier_word_a_q;
        end else if (addr == srlc_pkg::OFF_CARRIER_B) begin
            rd_d = carrier_word_b_q;
        end else if (addr == srlc_pkg::OFF_DIVIDER) begin
            rd_d = {20'h00000, out_div_q, ref_div_q};
        end else if (addr == srlc_pkg::OFF_RANGING_A) begin
            rd_d[RANGE_W-1:0] = range_a_q;
            rd_d[srlc_pkg::RNG_GO_BIT] = rng_busy && !sel_b_q;
            rd_d[srlc_pkg::RNG_FAULT_BIT] = fault_a_q;
            rd_d[srlc_pkg::RNG_TRACK_BIT] = track_a_q;
        end else if (addr == srlc_pkg::OFF_RANGING_B) begin
            rd_d[RANGE_W-1:0] = range_b_q;
            rd_d[srlc_pkg::RNG_GO_BIT] = rng_busy && sel_b_q;
            rd_d[srlc_pkg::RNG_FAULT_BIT] = fault_b_q;
            rd_d[srlc_pkg::RNG_TRACK_BIT] = track_b_q;
        end else if (addr == srlc_pkg::OFF_LOOP) begin
            rd_d[1:0] = flt_q;
        end else if (addr == srlc_pkg::OFF_LOOP_FAST) begin
            rd_d[1:0] = flt_fast_q;
        end else if (addr == srlc_pkg::OFF_CP) begin
            rd_d[7:0] = cp_q;
        end else if (addr == srlc_pkg::OFF_CP_FAST) begin
            rd_d[7:0] = cp_fast_q;
        end else if (addr == srlc_pkg::OFF_BOOST) begin
            rd_d[BOOST_W-1:0] = boost_len_q;
            rd_d[srlc_pkg::BOOST_EN_BIT] = boost_en_q;
        end else if (addr == srlc_pkg::OFF_SYNTH) begin
            rd_d[2:0] = {fast_active, use_b_q, synth_en_q};
        end else if (addr == srlc_pkg::OFF_IRQ_STAT) begin
            rd_d[3:0] = irq_stat_q;
        end else if (addr == srlc_pkg::OFF_IRQ_MASK) begin
            rd_d[3:0] = irq_mask_q;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            rdata <= rd_d;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule : srlc_top

/* srlc_top_chk.sv */
// assertions for the synthesizer ranging and loop control block
`timescale 1ns/1ps
module srlc_chk #(
    parameter int RANGE_W = 4,
    parameter int BOOST_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic irq,
    // analog loop
    input wire logic vco_high_pin,
    input wire logic vco_low_pin,
    input wire logic [31:0] carrier_word,
    input wire logic [7:0] reference_divider_ratio,
    input wire logic [3:0] output_band_divider,
    input wire logic [RANGE_W-1:0] vco_range,
    input wire srlc_pkg::srlc_loop_t loop_out,
    input wire logic synth_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // read answer only in the cycle after a strobe
    property p_rd_idle; !$past(rd_stb) |-> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside answer cycle");
    // register writes reach the analog settings two cycles later
    property p_car; wr_stb && addr == srlc_pkg::OFF_CARRIER_A |->
        ##2 carrier_word == $past(wdata, 2); endproperty
    a_car: assert property (p_car)
        else $error("carrier word not applied");
    property p_out; wr_stb && addr == srlc_pkg::OFF_DIVIDER |->
        ##2 output_band_divider == $past(wdata[11:8], 2); endproperty
    a_out: assert property (p_out)
        else $error("output divider not applied");
    property p_ref; wr_stb && addr == srlc_pkg::OFF_DIVIDER |->
        ##2 reference_divider_ratio == $past(wdata[7:0], 2); endproperty
    a_ref: assert property (p_ref)
        else $error("reference divider not applied");
    property p_flt; (wr_stb && addr == srlc_pkg::OFF_LOOP && !synth_en)
        ##1 !synth_en ##1 !synth_en |->
        loop_out.loop_filter_sel == $past(wdata[1:0], 2); endproperty
    a_flt: assert property (p_flt)
        else $error("filter select not applied");
    property p_cp; (wr_stb && addr == srlc_pkg::OFF_CP && !synth_en)
        ##1 !synth_en ##1 !synth_en |->
        loop_out.charge_pump == $past(wdata[7:0], 2); endproperty
    a_cp: assert property (p_cp)
        else $error("charge pump current not applied");
    property p_ext; $past(rst_n) && $past(rst_n, 2) |->
        loop_out.external_filter_pin ==
        (loop_out.loop_filter_sel == srlc_pkg::FLT_EXTERNAL); endproperty
    a_ext: assert property (p_ext)
        else $error("external filter pin disagrees with select");
    // go bit reads one just after a search is launched
    property p_go; (wr_stb && addr == srlc_pkg::OFF_RANGING_A && wdata[4])
        ##[1:3] (rd_stb && addr == srlc_pkg::OFF_RANGING_A) |=> rdata[4];
    endproperty
    a_go: assert property (p_go)
        else $error("go bit not set after launch");
    // main scenarios
    c_irq: cover property (irq);
    c_ext: cover property (loop_out.external_filter_pin);
    c_syn: cover property (synth_en);
endmodule : srlc_chk

bind srlc_top srlc_chk #(.RANGE_W(RANGE_W), .BOOST_W(BOOST_W)) u_chk (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
    .vco_high_pin(vco_high_pin), .vco_low_pin(vco_low_pin),
    .carrier_word(carrier_word),
    .reference_divider_ratio(reference_divider_ratio),
    .output_band_divider(output_band_divider), .vco_range(vco_range),
    .loop_out(loop_out), .synth_en(synth_en));

/* test_srlc_top.sv */
// self-checking testbench for the synthesizer ranging and loop control
`timescale 1ns/1ps
module test_srlc_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic vco_high_pin = 1'b0;
    logic vco_low_pin = 1'b0;
    logic [31:0] rdata, carrier_word, v, ca, cb, dv;
    logic irq, synth_en;
    logic rd_q = 1'b0;
    logic [7:0] reference_divider_ratio;
    logic [3:0] output_band_divider, vco_range;
    srlc_pkg::srlc_loop_t loop_out;
    logic [63:0] q[$];
    logic [63:0] e;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    srlc_top u_dut (.clock, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata, .irq, .vco_high_pin, .vco_low_pin, .carrier_word,
        .reference_divider_ratio, .output_band_divider, .vco_range,
        .loop_out, .synth_en);
    // 25 MHz clock
    always #20 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // read answers are compared against the oldest note
    always @(posedge clock) begin
        rd_q <= rd_stb;
        if (rd_q) begin
            e = q.pop_front();
            check("rdata", rdata & e[63:32], e[31:0]);
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        q.push_back({m, x & m});
        @(posedge clock);
        rd_stb <= 1'b0;
        @(posedge clock);
        v = rdata;
    endtask : rd
    task automatic st;
        repeat (3) @(posedge clock);
        #1;
    endtask : st
    // poll the go bit until the search ends
    task automatic poll(input logic [7:0] a);
        n = 0;
        rd(a, 32'h0, 32'h0);
        while (v[4] !== 1'b0 && n < 400) begin
            rd(a, 32'h0, 32'h0);
            n++;
        end
        check("search end", 32'(n < 400), 32'h1);
    endtask : poll
    // watchdog against a hang
    initial begin
        #800000;
        miscompares++;
        results();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("ref_div", {24'h0, reference_divider_ratio}, 32'h1);
        check("vco_range", {28'h0, vco_range}, 32'h8);
        rd(srlc_pkg::OFF_DIVIDER, 32'h101, '1);
        rd(srlc_pkg::OFF_RANGING_A, 32'h8, 32'h7f);
        rd(srlc_pkg::OFF_LOOP, 32'h1, '1);
        rd(srlc_pkg::OFF_CP, 32'h8, '1);
        rd(srlc_pkg::OFF_BOOST, 32'h100, '1);
        rd(8'h3c, 32'h0, '1);
        $display("test reset finished");
        ca = xs(32'h6eee);
        cb = xs(ca);
        dv = xs(cb) & 32'h0000_0fff;
        wr(srlc_pkg::OFF_CARRIER_A, ca);
        wr(srlc_pkg::OFF_CARRIER_B, cb);
        wr(srlc_pkg::OFF_DIVIDER, dv);
        st();
        check("carrier_word", carrier_word, ca);
        check("out_div", 32'(output_band_divider), 32'(dv[11:8]));
        check("ref_div", 32'(reference_divider_ratio), 32'(dv[7:0]));
        rd(srlc_pkg::OFF_CARRIER_A, ca, '1);
        rd(srlc_pkg::OFF_CARRIER_B, cb, '1);
        rd(srlc_pkg::OFF_DIVIDER, dv, '1);
        for (int f = 0; f < 4; f++) begin
            wr(srlc_pkg::OFF_LOOP, 32'(f));
            st();
            check("flt", {30'h0, loop_out.loop_filter_sel}, 32'(f));
            check("ext", 32'(loop_out.external_filter_pin), 32'(!f));
        end
        $display("test settings finished");
        wr(srlc_pkg::OFF_RANGING_A, 32'h18);
        rd(srlc_pkg::OFF_RANGING_A, 32'h10, 32'h10);
        poll(srlc_pkg::OFF_RANGING_A);
        rd(srlc_pkg::OFF_RANGING_A, 32'h8, 32'h3f);
        rd(srlc_pkg::OFF_IRQ_STAT, 32'h1, 32'hf);
        wr(srlc_pkg::OFF_IRQ_MASK, 32'h1);
        st();
        check("irq", {31'h0, irq}, 32'h1);
        wr(srlc_pkg::OFF_IRQ_MASK, 32'h0);
        st();
        check("irq", {31'h0, irq}, 32'h0);
        wr(srlc_pkg::OFF_IRQ_STAT, 32'hf);
        rd(srlc_pkg::OFF_IRQ_STAT, 32'h0, 32'hf);
        vco_high_pin <= 1'b1;
        wr(srlc_pkg::OFF_RANGING_B, 32'h18);
        st();
        check("carrier_word", carrier_word, cb);
        poll(srlc_pkg::OFF_RANGING_B);
        rd(srlc_pkg::OFF_RANGING_B, 32'h2f, 32'h3f);
        rd(srlc_pkg::OFF_IRQ_STAT, 32'h6, 32'hf);
        vco_high_pin <= 1'b0;
        wr(srlc_pkg::OFF_IRQ_STAT, 32'hf);
        $display("test ranging finished");
        wr(srlc_pkg::OFF_LOOP, 32'h3);
        wr(srlc_pkg::OFF_CP, 32'h11);
        wr(srlc_pkg::OFF_LOOP_FAST, 32'h2);
        wr(srlc_pkg::OFF_CP_FAST, 32'h5a);
        wr(srlc_pkg::OFF_BOOST, 32'h0001_0014);
        wr(srlc_pkg::OFF_SYNTH, 32'h1);
        n = 0;
        repeat (60) begin
            @(posedge clock);
            #1;
            if (loop_out.charge_pump === 8'h5a) n++;
        end
        check("fast cycles", n, 32'd20);
        check("loop_out", 32'(loop_out), {21'h0, 2'h3, 8'h11, 1'b0});
        check("synth_en", {31'h0, synth_en}, 32'h1);
        rd(srlc_pkg::OFF_IRQ_STAT, 32'h8, 32'h8);
        $display("test boost finished");
        results();
    end
endmodule : test_srlc_top
